// ===== dv/ppc_pin_model.sv
// Purpose: board-side model of the eight port pins
// Assumes: the testbench sets the external drive of each pin
// Notes: a released line with no pull toggles every cycle
`timescale 1ns/1ps
module ppc_pin_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic [7:0] float_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // moving pattern so a floating line never keeps its last level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            float_reg <= 8'h00;
        end else begin
            float_reg <= ~float_reg;
        end
    end
    // resolve each wire: port drive, board drive, pulls, then float
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : float_reg[i];
        end
    end
endmodule

// ===== dv/testbench.sv
// Purpose: self-checking bench for the pin configuration port
// Assumes: zero-wait bus slave, pins resolved by the board model
// Notes: seeded random pins and timer waveforms; sense and drive codes swept in order
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] A_MSK = {ppc_pkg::IDX_MPC_MASK, 2'b00};
    localparam logic [7:0] A_IN = {ppc_pkg::IDX_INPUT, 2'b00};
    localparam logic [7:0] A_LVL = {ppc_pkg::IDX_IRQ_LEVEL, 2'b00};
    localparam logic [7:0] A_IMK = {ppc_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_FLG = {ppc_pkg::IDX_FLAGS, 2'b00};
    localparam logic [7:0] A_RMP = {ppc_pkg::IDX_REMAP, 2'b00};
    logic hclk = 1'b0, hresetn, hsel, hwrite, hreadyout, hresp, port_irq;
    logic ta, tao, t2, t2o;
    logic [1:0] htrans, lvl;
    logic [7:0] haddr, pin_in, pin_out, pin_oe, pu, pd, hold, ibuf, pout, pdir, pev;
    logic [7:0] ext_val, ext_en;
    logic [31:0] hwdata, hrdata;
    int n_fail = 0, compares = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #10 hclk = ~hclk;
    ppc_port #(.PINS(8), .BUFFER_CTRL(1'b1)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pu), .pull_down_en(pd), .hold_last_level_en(hold),
        .input_buffer_en(ibuf), .port_out_value(pout), .port_dir(pdir),
        .timer_compare_out_a(ta), .timer_compare_out_a_on(tao), .timer2_compare_out_a(t2),
        .timer2_compare_out_a_on(t2o), .pin_event(pev), .port_irq(port_irq),
        .irq_priority_level(lvl));
    ppc_pin_model board (.hclk(hclk), .hresetn(hresetn), .pin_out(pin_out),
        .pin_oe(pin_oe), .pull_up_en(pu), .pull_down_en(pd), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single word transfer; master holds each phase until hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask
    task automatic drv(input int p, input logic b);
        ext_val[p] <= b;
        pause(8);
    endtask
    function automatic logic [7:0] ca(input int p);
        return 8'(8'h40 + 4 * p);
    endfunction
    // flag expected for a falling (rise=0) or rising edge under sense code c
    function automatic logic hit(input logic [2:0] c, input logic rise);
        return rise ? (c == 3'h0 || c == 3'h1) : (c == 3'h0 || c == 3'h2 || c == 3'h3);
    endfunction
    // t = {timer a, a on, timer2, timer2 on}
    function automatic logic exp_p4(input logic r, input logic [3:0] t, input logic v);
        return (r && t[2]) ? (t[3] | (t[1] & t[0])) : (t[0] ? t[1] : v);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        int p;
        logic [2:0] c;
        logic [7:0] v;
        logic [3:0] t;
        {hresetn, hsel, hwrite, ta, tao, t2, t2o} = 7'h0;
        {htrans, haddr, hwdata, pout, pdir} = 0;
        ext_val = 8'hff;
        ext_en = 8'hff;
        void'($urandom(32'he807));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (p = 0; p < 8; p++) rchk(ca(p), 32'h0);
        rchk(A_FLG, 32'h0);
        rchk(A_RMP, 32'h0);
        wr(8'hfc, 32'hff);
        rchk(8'hfc, 32'h0);
        wr(A_LVL, 32'hff);
        rchk(A_LVL, 32'h3);
        wr(A_RMP, 32'hff);
        rchk(A_RMP, 32'h1);
        wr(ca(5), 32'hff);
        wr(A_MSK, 32'h05);
        rchk(A_MSK, 32'h05);
        wr(ca(3), 32'h1b);
        rchk(ca(2), 32'h1b);
        rchk(ca(3), 32'h0);
        rchk(ca(5), 32'h7f);
        rchk(A_MSK, 32'h0);
        wr(ca(3), 32'h02);
        rchk(ca(3), 32'h02);
        rchk(ca(0), 32'h1b);
        wr(A_MSK, 32'hff);
        wr(ca(0), 32'h0);
        rchk(ca(5), 32'h0);
        // every sense code on a random pin: fall, rise, then clear
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            p = $urandom_range(7, 0);
            wr(A_IMK, 32'h1 << p);
            wr(ca(p), 32'(c));
            wr(A_FLG, 32'hff);
            drv(p, 1'b0);
            rchk(A_FLG, 32'(hit(c, 1'b0)) << p);
            chk(port_irq, hit(c, 1'b0));
            drv(p, 1'b1);
            if (c == 3'h3) chk(pev[p], 1'b1);
            v = 8'(hit(c, 1'b0) | hit(c, 1'b1)) << p;
            rchk(A_FLG, v);
            wr(A_FLG, ~(32'h1 << p));
            rchk(A_FLG, v);
            wr(A_FLG, 32'h1 << p);
            rchk(A_FLG, 32'h0);
            chk(port_irq, 1'b0);
            wr(ca(p), 32'h0);
        end
        wr(A_IMK, 32'h0);
        drv(p, 1'b0);
        rchk(A_FLG, 32'h0);
        wr(A_IMK, 32'hff);
        wr(A_LVL, 32'h0);
        drv(p, 1'b1);
        chk(port_irq, 1'b0);
        wr(A_LVL, 32'h2);
        chk(lvl, 2'h2);
        chk(port_irq, 1'b1);
        wr(A_FLG, 32'hff);
        wr(A_IMK, 32'h0);
        // drive and pull styles for every code, as input and as output
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            @(posedge hclk) pdir[p] <= 1'b0;
            wr(ca(p), {29'h0, c} << 3);
            pause(2);
            chk(pu[p], c == 3'h3 || c == 3'h7);
            chk(pd[p], c == 3'h2 || c == 3'h6);
            chk(hold[p], c == 3'h1);
            for (int b = 0; b < 2; b++) begin
                @(posedge hclk) pdir[p] <= 1'b1;
                pout[p] <= b[0];
                pause(2);
                chk(pin_oe[p], c[2] ? c[0] ^ b[0] : 1'b1);
            end
        end
        @(posedge hclk) pdir <= 8'h0;
        wr(ca(p), 32'h0);
        v = 8'($urandom);
        ext_val <= v;
        pause(8);
        rchk(A_IN, 32'(v));
        wr(ca(p), 32'h47);
        rchk(A_IN, 32'(v & ~(8'h1 << p)));
        chk(ibuf[p], 1'b0);
        wr(ca(p), 32'h40);
        rchk(A_IN, 32'(v ^ (8'h1 << p)));
        pdir[p] <= 1'b1;
        pout[p] <= 1'b1;
        pause(2);
        chk(pin_out[p], 1'b0);
        wr(ca(p), 32'h0);
        // timer output a placement with and without the move bit
        @(posedge hclk) pdir <= 8'hff;
        for (int k = 0; k < 12; k++) begin
            t = (k == 1) ? 4'h7 : 4'($urandom); // corner: both timers on with the move bit
            v = 8'($urandom);
            @(posedge hclk) {ta, tao, t2, t2o} <= t;
            pout <= v;
            wr(A_RMP, 32'(k % 2));
            pause(2);
            chk(pin_out[4], exp_p4(k % 2 == 1, t, v[4]));
            chk(pin_out[0], (k % 2 == 0 && t[2]) ? t[3] : v[0]);
        end
        end_sim();
    end
endmodule

// ===== src/ppc_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for the port pins
// Assumes: pins change asynchronously to hclk
// Notes: a change is taken once the second and third stages agree
`timescale 1ns/1ps
module ppc_pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser chain; stage1 feeds stage2 only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // accept a bit only where the two late stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_reg <= '0;
        end else begin
            level_reg <= (stage2_reg & stage3_reg) | (level_reg & (stage2_reg | stage3_reg));
        end
    end

    assign pin_level = level_reg;
endmodule

// ===== src/ppc_pkg.sv
// Purpose: shared constants of the pin configuration and pin-change interrupt block
// Assumes: register indices sit on word addresses (byte address = 4 * index)
// Notes: every offset, field position and reset value is named here once
package ppc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_MPC_MASK = 6'h00;
    localparam logic [5:0] IDX_INPUT = 6'h08;
    localparam logic [5:0] IDX_IRQ_LEVEL = 6'h09;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h0a;
    localparam logic [5:0] IDX_FLAGS = 6'h0c;
    localparam logic [5:0] IDX_REMAP = 6'h0e;
    localparam logic [5:0] IDX_PIN_CTRL = 6'h10;
    localparam logic [5:0] IDX_PIN_CTRL_LAST = 6'h17;

    // per_pin_control field positions
    localparam int unsigned INV_BIT = 6;
    localparam int unsigned DRV_LSB = 3;
    localparam int unsigned SENSE_LSB = 0;
    localparam logic [7:0] PIN_CTRL_WMASK = 8'h7f;

    // pin_location_remap field position
    localparam int unsigned REMAP_TIMER_A_BIT = 0;

    // irq level field width
    localparam int unsigned LVL_W = 2;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_PIN_CTRL = 8'h00;
    localparam logic [1:0] RST_LVL = 2'h0;

    // drive_pull_select codes
    localparam logic [2:0] DRV_TOTEM = 3'h0;
    localparam logic [2:0] DRV_HOLD_LAST_LEVEL = 3'h1;
    localparam logic [2:0] DRV_PULLDOWN = 3'h2;
    localparam logic [2:0] DRV_PULLUP = 3'h3;
    localparam logic [2:0] DRV_WIRED_OR = 3'h4;
    localparam logic [2:0] DRV_WIRED_AND = 3'h5;
    localparam logic [2:0] DRV_OPEN_SOURCE_PULLDOWN = 3'h6;
    localparam logic [2:0] DRV_OPEN_DRAIN_PULLUP = 3'h7;

    // sense_select codes
    localparam logic [2:0] SENSE_ANY_EDGE = 3'h0;
    localparam logic [2:0] SENSE_RISING = 3'h1;
    localparam logic [2:0] SENSE_FALLING = 3'h2;
    localparam logic [2:0] SENSE_LOW_LEVEL = 3'h3;
    localparam logic [2:0] SENSE_BUFFER_FORCED = 3'h6;
    localparam logic [2:0] SENSE_BUFFER_OFF = 3'h7;
endpackage

// ===== src/ppc_port.sv
// Purpose: pin configuration, pin-change flags and compare-output remap of an 8-pin port
// Assumes: AHB-Lite slave, word transfers, zero wait states, OKAY only
// Notes: direction and output value come from outside this block
`timescale 1ns/1ps
// How it works
// - a pin is an interrupt source only while its source mask bit is one
// - a flag sets when an enabled pin matches its sense mode
// - writing one clears a flag; writing zero leaves it
// - remap bit moves compare output A from pin 0 to pin 4
// - with remap and both timers active, pin 4 carries their OR
// - control bit 6 inverts both driven and read pin data
// - drive field selects totem, pulls, keeper, wired-OR or wired-AND styles
// - sense codes: any edge, rising, falling, low level; 100 and 101 reserved
// - sense 110 forces the input buffer on; 111 turns it off
// - the sense mode governs both flags and events
// - in low-level mode a high pin gives continuous events, low gives none
// - forced-on and off buffer codes exist only on the first ports
// - writing one to a multi-pin mask bit puts that pin in the group
// - with a mask set, a control write updates exactly the masked pins
// - the multi-pin mask clears after any pin control write
// - a nonzero irq level enables the port irq and sets its priority
// - the input register shows each pin while its buffer is on
module ppc_port #(
    parameter int unsigned PINS = 8,
    parameter bit BUFFER_CTRL = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pull_up_en,
    output logic [PINS-1:0] pull_down_en,
    output logic [PINS-1:0] hold_last_level_en,
    output logic [PINS-1:0] input_buffer_en,
    input wire logic [PINS-1:0] port_out_value,
    input wire logic [PINS-1:0] port_dir,
    input wire logic timer_compare_out_a,
    input wire logic timer_compare_out_a_on,
    input wire logic timer2_compare_out_a,
    input wire logic timer2_compare_out_a_on,
    output logic [PINS-1:0] pin_event,
    output logic port_irq,
    output logic [1:0] irq_priority_level
);
    logic [7:0] multi_pin_config_mask_reg;
    logic [7:0] interrupt_source_mask_reg;
    logic [7:0] pin_interrupt_flags_reg;
    logic [7:0] pin_interrupt_flags_next;
    logic timer_out_a_move_reg;
    logic [1:0] irq_level_reg;
    logic [7:0] per_pin_control_reg [PINS];
    logic wr_pend_reg;
    logic [5:0] wr_idx_reg;
    logic [31:0] rdata_reg;
    logic [PINS-1:0] sync_level;
    logic [PINS-1:0] in_data;
    logic [PINS-1:0] in_prev_reg;
    logic [4:0] warm_reg;
    logic [PINS-1:0] buffer_on;
    logic [PINS-1:0] sense_hit;
    logic [PINS-1:0] event_hit;
    logic [PINS-1:0] flag_set;
    logic [PINS-1:0] drive_data;
    logic [PINS-1:0] event_reg;
    logic [PINS-1:0] out_reg;
    logic [PINS-1:0] oe_reg;
    logic [PINS-1:0] pu_reg;
    logic [PINS-1:0] pd_reg;
    logic [PINS-1:0] keep_reg;
    logic addr_take;
    logic [5:0] addr_idx;
    logic wr_ctrl;
    logic [7:0] wr_byte;
    logic [7:0] read_byte;

    // word index of a byte address
    function automatic logic [5:0] word_idx(input logic [7:0] addr);
        return addr[7:2];
    endfunction

    // sense match for one pin; ev selects event meaning over flag meaning
    function automatic logic sense_match(input logic [2:0] code, input logic cur,
                                         input logic prev, input logic ev);
        logic hit;
        hit = 1'b0;
        unique case (code)
            ppc_pkg::SENSE_ANY_EDGE: hit = cur ^ prev;
            ppc_pkg::SENSE_RISING: hit = cur & ~prev;
            ppc_pkg::SENSE_FALLING: hit = ~cur & prev;
            ppc_pkg::SENSE_LOW_LEVEL: hit = ev ? cur : ~cur;
            default: hit = 1'b0; // reserved and buffer codes sense nothing
        endcase
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    assign addr_take = hsel & hready & htrans[1];
    assign addr_idx = word_idx(haddr);
    assign wr_byte = hwdata[7:0];
    assign wr_ctrl = wr_pend_reg && wr_idx_reg >= ppc_pkg::IDX_PIN_CTRL
                     && wr_idx_reg <= ppc_pkg::IDX_PIN_CTRL_LAST;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // write pending into data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 6'h00;
        end else begin
            wr_pend_reg <= addr_take & hwrite;
            wr_idx_reg <= addr_idx;
        end
    end

    // read mux; unmapped and reserved bits read zero
    always_comb begin
        read_byte = ppc_pkg::RST_BYTE;
        unique case (addr_idx)
            ppc_pkg::IDX_MPC_MASK: read_byte = multi_pin_config_mask_reg;
            ppc_pkg::IDX_INPUT: read_byte = in_data & buffer_on;
            ppc_pkg::IDX_IRQ_LEVEL: read_byte = {6'h00, irq_level_reg};
            ppc_pkg::IDX_IRQ_MASK: read_byte = interrupt_source_mask_reg;
            ppc_pkg::IDX_FLAGS: read_byte = pin_interrupt_flags_reg;
            ppc_pkg::IDX_REMAP: read_byte = {7'h00, timer_out_a_move_reg};
            default: begin
                if (addr_idx >= ppc_pkg::IDX_PIN_CTRL && addr_idx <= ppc_pkg::IDX_PIN_CTRL_LAST)
                    read_byte = per_pin_control_reg[addr_idx[2:0]];
            end
        endcase
    end

    // read data latched at the address phase, stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 32'h00000000;
        end else if (addr_take && !hwrite) begin
            rdata_reg <= {24'h000000, read_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_source_mask_reg <= ppc_pkg::RST_BYTE;
            irq_level_reg <= ppc_pkg::RST_LVL;
            timer_out_a_move_reg <= 1'b0;
        end else if (wr_pend_reg) begin
            if (wr_idx_reg == ppc_pkg::IDX_IRQ_MASK)
                interrupt_source_mask_reg <= wr_byte;
            if (wr_idx_reg == ppc_pkg::IDX_IRQ_LEVEL)
                irq_level_reg <= wr_byte[ppc_pkg::LVL_W-1:0];
            if (wr_idx_reg == ppc_pkg::IDX_REMAP)
                timer_out_a_move_reg <= wr_byte[ppc_pkg::REMAP_TIMER_A_BIT];
        end
    end

    // multi-pin mask: set by write, cleared by any pin control write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            multi_pin_config_mask_reg <= ppc_pkg::RST_BYTE;
        end else if (wr_ctrl) begin
            multi_pin_config_mask_reg <= ppc_pkg::RST_BYTE;
        end else if (wr_pend_reg && wr_idx_reg == ppc_pkg::IDX_MPC_MASK) begin
            multi_pin_config_mask_reg <= wr_byte;
        end
    end

    // pin control registers; masked group or the addressed pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < PINS; i++)
                per_pin_control_reg[i] <= ppc_pkg::RST_PIN_CTRL;
        end else if (wr_ctrl) begin
            for (int i = 0; i < PINS; i++) begin
                if (multi_pin_config_mask_reg != 8'h00) begin
                    if (multi_pin_config_mask_reg[i])
                        per_pin_control_reg[i] <= wr_byte & ppc_pkg::PIN_CTRL_WMASK;
                end else if (wr_idx_reg[2:0] == 3'(i)) begin
                    per_pin_control_reg[i] <= wr_byte & ppc_pkg::PIN_CTRL_WMASK;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input path
    ppc_pin_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_async(pin_in),
        .pin_level(sync_level)
    );

    // inversion, buffer control and sense decode per pin
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            in_data[i] = sync_level[i] ^ per_pin_control_reg[i][ppc_pkg::INV_BIT];
            buffer_on[i] = !(BUFFER_CTRL && per_pin_control_reg[i][2:0]
                             == ppc_pkg::SENSE_BUFFER_OFF);
            sense_hit[i] = warm_reg[4] && sense_match(per_pin_control_reg[i][2:0], in_data[i],
                in_prev_reg[i], 1'b0);
            event_hit[i] = warm_reg[4] && buffer_on[i] && sense_match(per_pin_control_reg[i][2:0],
                in_data[i], in_prev_reg[i], 1'b1);
        end
    end

    assign flag_set = sense_hit & buffer_on & interrupt_source_mask_reg;

    // previous input, post-reset warm-up and event outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_prev_reg <= '0;
            warm_reg <= '0;
            event_reg <= '0;
        end else begin
            in_prev_reg <= in_data;
            warm_reg <= {warm_reg[3:0], 1'b1}; // no false edge while the sync chain fills
            event_reg <= event_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: write one clears, a new set wins over the clear
    always_comb begin
        pin_interrupt_flags_next = pin_interrupt_flags_reg;
        if (wr_pend_reg && wr_idx_reg == ppc_pkg::IDX_FLAGS)
            pin_interrupt_flags_next = pin_interrupt_flags_next & ~wr_byte;
        pin_interrupt_flags_next = pin_interrupt_flags_next | flag_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_interrupt_flags_reg <= ppc_pkg::RST_BYTE;
        end else begin
            pin_interrupt_flags_reg <= pin_interrupt_flags_next;
        end
    end

    // port irq request and its level
    assign port_irq = (|pin_interrupt_flags_reg) && (irq_level_reg != 2'h0);
    assign irq_priority_level = irq_level_reg;
    assign pin_event = event_reg;
    assign input_buffer_en = buffer_on;

    ////////////////////////////////////////////////////////////////////////////
    // output data with timer compare routing
    always_comb begin
        drive_data = port_out_value;
        if (!timer_out_a_move_reg) begin
            if (timer_compare_out_a_on)
                drive_data[0] = timer_compare_out_a;
            if (timer2_compare_out_a_on)
                drive_data[4] = timer2_compare_out_a;
        end else if (timer_compare_out_a_on || timer2_compare_out_a_on) begin
            drive_data[4] = (timer_compare_out_a_on & timer_compare_out_a)
                            | (timer2_compare_out_a_on & timer2_compare_out_a);
        end
    end

    // drive style and pulls per pin, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_reg <= '0;
            oe_reg <= '0;
            pu_reg <= '0;
            pd_reg <= '0;
            keep_reg <= '0;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                logic v;
                logic [2:0] drv;
                v = drive_data[i] ^ per_pin_control_reg[i][ppc_pkg::INV_BIT];
                drv = per_pin_control_reg[i][ppc_pkg::DRV_LSB +: 3];
                out_reg[i] <= v;
                oe_reg[i] <= port_dir[i];
                pu_reg[i] <= 1'b0;
                pd_reg[i] <= 1'b0;
                keep_reg[i] <= 1'b0;
                unique case (drv)
                    ppc_pkg::DRV_TOTEM: ;
                    ppc_pkg::DRV_HOLD_LAST_LEVEL: keep_reg[i] <= 1'b1;
                    ppc_pkg::DRV_PULLDOWN: pd_reg[i] <= ~port_dir[i];
                    ppc_pkg::DRV_PULLUP: pu_reg[i] <= ~port_dir[i];
                    ppc_pkg::DRV_WIRED_OR: oe_reg[i] <= port_dir[i] & v;
                    ppc_pkg::DRV_WIRED_AND: oe_reg[i] <= port_dir[i] & ~v;
                    ppc_pkg::DRV_OPEN_SOURCE_PULLDOWN: begin
                        oe_reg[i] <= port_dir[i] & v;
                        pd_reg[i] <= 1'b1;
                    end
                    ppc_pkg::DRV_OPEN_DRAIN_PULLUP: begin
                        oe_reg[i] <= port_dir[i] & ~v;
                        pu_reg[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign pin_out = out_reg;
    assign pin_oe = oe_reg;
    assign pull_up_en = pu_reg;
    assign pull_down_en = pd_reg;
    assign hold_last_level_en = keep_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_FLAG_CLEAR: assert property (
        wr_pend_reg && wr_idx_reg == ppc_pkg::IDX_FLAGS
        |=> (pin_interrupt_flags_reg & $past(wr_byte) & ~$past(flag_set)) == 8'h00)
        else $error("flag not cleared by write of one");
    AST_SET_WINS: assert property (
        |flag_set |=> (pin_interrupt_flags_reg & $past(flag_set)) == $past(flag_set))
        else $error("flag set lost");
    AST_NO_SOURCE: assert property (
        !interrupt_source_mask_reg[0] |=> !$rose(pin_interrupt_flags_reg[0]))
        else $error("masked pin set a flag");
    AST_IRQ_DROP: assert property (
        pin_interrupt_flags_reg == 8'h00 || irq_level_reg == 2'h0 |-> !port_irq)
        else $error("irq without flag or level");
    AST_MASK_AUTOCLR: assert property (
        wr_ctrl |=> multi_pin_config_mask_reg == 8'h00)
        else $error("multi-pin mask not cleared");
    AST_MULTI_WRITE: assert property (
        wr_ctrl && multi_pin_config_mask_reg[0]
        |=> per_pin_control_reg[0] == ($past(wr_byte) & ppc_pkg::PIN_CTRL_WMASK))
        else $error("masked pin not updated");
    AST_SINGLE_WRITE: assert property (
        wr_ctrl && multi_pin_config_mask_reg == 8'h00 && wr_idx_reg[2:0] != 3'h0
        |=> $stable(per_pin_control_reg[0]))
        else $error("unaddressed pin changed");
    AST_REMAP_OR: assert property (
        timer_out_a_move_reg && timer_compare_out_a_on && timer2_compare_out_a_on
        && per_pin_control_reg[4][6:3] == 4'h0
        |=> pin_out[4] == $past(timer_compare_out_a | timer2_compare_out_a))
        else $error("remapped pin is not the OR");
    AST_LEVEL_EVENT: assert property (
        per_pin_control_reg[0][2:0] == ppc_pkg::SENSE_LOW_LEVEL
        |=> pin_event[0] == $past(in_data[0]))
        else $error("level event wrong");

    COV_MULTI: cover property (wr_ctrl && multi_pin_config_mask_reg != 8'h00);
    COV_FLAG_IRQ: cover property ($rose(port_irq));
    COV_REMAP: cover property (timer_out_a_move_reg && timer_compare_out_a_on
                               && timer2_compare_out_a_on);
endmodule
